// ===== verilog/epp_parallel_port.sv
// EPP/ECP parallel port controller: register set, enhanced cycles, shared FIFO and forward
// transmitter, reverse run-length decompression.
// Assumes I/O strobes and port pins are synchronous to clk_sys_i; address and write data
// stand stable while the write strobe is low and at the cycle of its rising edge.
`timescale 1ns/10ps
`default_nettype none

module epp_parallel_port
	import epp_pkg::*;
#(
	parameter int FIFO_DEPTH = 16,
	parameter int TIMEOUT_CYC = ENH_TIMEOUT_CYC
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [15:0] io_addr_i,
	input wire logic io_wr_n_i,
	input wire logic io_rd_n_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	output logic io_ready_o,
	output logic irq_o,
	input wire logic [15:0] base_addr_config_i,
	input wire logic enhanced_option_config_i,
	input wire logic chip_mode_config_i,
	input wire logic legacy_handshake_i,
	input wire logic [7:0] port_lines_i,
	output logic [7:0] port_lines_o,
	output logic port_lines_oe_o,
	output logic strobe_out_o,
	output logic auto_feed_out_o,
	output logic select_in_out_o,
	output logic periph_init_n_o,
	input wire logic acknowledge_in_n_i,
	input wire logic busy_i,
	input wire logic paper_error_in_i,
	input wire logic select_i,
	input wire logic fault_in_n_i
);

	localparam int PW = $clog2(FIFO_DEPTH);
	localparam int CW = $clog2(TIMEOUT_CYC + 1);
	localparam logic [PW:0] FIFO_FULL_CNT = (PW + 1)'(FIFO_DEPTH);
	localparam logic [CW-1:0] TIMEOUT_LAST = CW'(TIMEOUT_CYC - 1);
	localparam logic [7:0] SETUP_LAST = 8'(TX_SETUP_CYC - 1);
	localparam logic [7:0] STROBE_LAST = 8'(TX_STROBE_CYC - 1);

	typedef struct packed {
		logic [2:0] mode;
		logic [2:0] ext_ctl;
		logic [5:0] ctl;
		logic [5:0] cfgb;
		logic [7:0] data_latch;
		logic tmout;
		logic wr_n_q;
		logic rd_n_q;
		logic ack_q;
		logic [7:0] rdata;
		logic irq;
		epp_enh_state_e enh_st;
		logic enh_wr;
		logic enh_addr;
		logic enh_seen_low;
		logic [7:0] enh_byte;
		logic [CW-1:0] enh_cnt;
		logic [FIFO_DEPTH-1:0][8:0] mem;
		logic [PW:0] wptr;
		logic [PW:0] rptr;
		logic [8:0] buf0;
		logic [8:0] buf1;
		logic [1:0] buf_cnt;
		epp_tx_state_e tx_st;
		logic [8:0] tx_byte;
		logic [7:0] tx_cnt;
		logic rle_pend;
		logic [6:0] rle_cnt;
		logic [7:0] rep;
		logic [8:0] rep_byte;
	} epp_state_s;

	epp_state_s s;
	epp_state_s next_s;

	logic wr_edge;
	logic rd_edge;
	logic [15:0] off;
	logic enh_on;
	logic dir_eff;
	logic fwd_mode;
	logic rev_mode;
	logic [PW:0] fcount;
	logic fifo_full;
	logic fifo_empty;
	logic push;
	logic pop;
	logic [8:0] push_data;
	logic [8:0] head;
	logic enh_start;
	logic enh_done;
	logic take;
	logic periph_wait_n;
	logic [7:0] status_rd;
	logic fifo_wr_addr;

	// Wait shares the busy pin while an enhanced cycle runs
	assign periph_wait_n = busy_i;

	// Next-state logic for the whole port
	always_comb begin
		next_s = s;
		push = 1'b0;
		pop = 1'b0;
		push_data = 9'h000;
		enh_start = 1'b0;
		enh_done = 1'b0;
		take = 1'b0;
		wr_edge = ~s.wr_n_q & io_wr_n_i;
		rd_edge = s.rd_n_q & ~io_rd_n_i;
		off = io_addr_i - base_addr_config_i;
		enh_on = (s.mode == MODE_ENH) && enhanced_option_config_i && chip_mode_config_i;
		dir_eff = s.ctl[CTL_DIR_BIT] && (s.mode != MODE_STD) && (s.mode != MODE_FIFO);
		fwd_mode = (s.mode == MODE_FIFO) || ((s.mode == MODE_EXT) && !s.ctl[CTL_DIR_BIT]);
		rev_mode = (s.mode == MODE_EXT) && s.ctl[CTL_DIR_BIT];
		fcount = s.wptr - s.rptr;
		fifo_full = (fcount == FIFO_FULL_CNT);
		fifo_empty = (s.wptr == s.rptr);
		head = s.mem[s.rptr[PW-1:0]];
		fifo_wr_addr = (off == OFF_FIFO) || ((off == OFF_DATA) && (s.mode == MODE_EXT));
		status_rd = {~busy_i, acknowledge_in_n_i, paper_error_in_i, select_i, fault_in_n_i,
			ONES2, (enh_on ? s.tmout : 1'b1)};
		next_s.wr_n_q = io_wr_n_i;
		next_s.rd_n_q = io_rd_n_i;
		next_s.ack_q = acknowledge_in_n_i;

		// Acknowledge rising edge interrupt, one cycle per edge
		next_s.irq = s.ctl[CTL_IRQEN_BIT] && !s.ack_q && acknowledge_in_n_i;

		// Host writes take effect on the trailing edge of the write strobe
		if (wr_edge) begin
			if (off == OFF_DATA) begin
				if ((s.mode == MODE_STD) || (s.mode == MODE_BIDIR)) begin
					next_s.data_latch = io_wdata_i;
				end else if (fwd_mode && (s.mode == MODE_EXT) && !fifo_full) begin
					push = 1'b1;
					push_data = {1'b1, io_wdata_i};
				end
			end else if (off == OFF_STATUS) begin
				if (io_wdata_i[STAT_TMOUT_BIT]) begin
					next_s.tmout = 1'b0;
				end
			end else if (off == OFF_CONTROL) begin
				next_s.ctl = io_wdata_i[5:0];
			end else if (enh_on && (off >= OFF_ENH_ADDR) && (off <= OFF_ENH_DATA3)) begin
				if (s.enh_st == ENH_IDLE) begin
					enh_start = 1'b1;
					next_s.enh_wr = 1'b1;
					next_s.enh_addr = (off == OFF_ENH_ADDR);
					next_s.enh_byte = io_wdata_i;
				end
			end else if (off == OFF_FIFO) begin
				if ((fwd_mode || (s.mode == MODE_TEST)) && !fifo_full) begin
					push = 1'b1;
					push_data = {1'b0, io_wdata_i};
				end
			end else if (off == OFF_CONFIG_B) begin
				if (s.mode == MODE_CFG) begin
					next_s.cfgb = io_wdata_i[5:0];
				end
			end else if (off == OFF_EXT_CTL) begin
				next_s.mode = io_wdata_i[7:5];
				next_s.ext_ctl = io_wdata_i[4:2];
			end
		end

		// Host reads are captured on the leading edge of the read strobe
		if (rd_edge) begin
			next_s.rdata = UNMAPPED_READ;
			if (off == OFF_DATA) begin
				next_s.rdata = port_lines_i;
			end else if (off == OFF_STATUS) begin
				next_s.rdata = status_rd;
			end else if (off == OFF_CONTROL) begin
				next_s.rdata = {ONES2, dir_eff, s.ctl[4:0]};
			end else if (enh_on && (off >= OFF_ENH_ADDR) && (off <= OFF_ENH_DATA3)) begin
				if (s.enh_st == ENH_IDLE) begin
					enh_start = 1'b1;
					next_s.enh_wr = 1'b0;
					next_s.enh_addr = (off == OFF_ENH_ADDR);
				end
			end else if (off == OFF_FIFO) begin
				if (s.mode == MODE_CFG) begin
					next_s.rdata = CONFIG_A_VALUE;
				end else if (((s.mode == MODE_TEST) || rev_mode) && !fifo_empty) begin
					next_s.rdata = head[7:0];
					pop = 1'b1;
				end
			end else if ((off == OFF_CONFIG_B) && (s.mode == MODE_CFG)) begin
				next_s.rdata = {1'b0, s.irq, s.cfgb};
			end else if (off == OFF_EXT_CTL) begin
				next_s.rdata = {s.mode, s.ext_ctl, fifo_full, fifo_empty};
			end
		end

		// Enhanced cycle sequencer with watchdog
		if (enh_start) begin
			next_s.enh_cnt = '0;
			next_s.enh_seen_low = 1'b0;
			if (!legacy_handshake_i && periph_wait_n) begin
				next_s.enh_st = ENH_HOLD;
			end else begin
				next_s.enh_st = ENH_STRB;
			end
		end else if (s.enh_st != ENH_IDLE) begin
			next_s.enh_cnt = s.enh_cnt + CW'(1);
			if (s.enh_cnt == TIMEOUT_LAST) begin
				next_s.enh_st = ENH_IDLE;
			end else begin
				unique case (s.enh_st)
					ENH_HOLD: begin
						if (!periph_wait_n) begin
							next_s.enh_st = ENH_STRB;
						end
					end
					ENH_STRB: begin
						if (!periph_wait_n) begin
							next_s.enh_seen_low = 1'b1;
						end
						if (periph_wait_n && (!legacy_handshake_i || s.enh_seen_low)) begin
							enh_done = 1'b1;
						end
					end
					default: begin
						next_s.enh_st = ENH_IDLE;
					end
				endcase
			end
		end
		if (enh_done) begin
			next_s.enh_st = ENH_IDLE;
			if (!s.enh_wr) begin
				next_s.rdata = port_lines_i;
			end
		end
		// Expiry sets the flag after any clear, so a timeout never gets lost
		if ((s.enh_st != ENH_IDLE) && (s.enh_cnt == TIMEOUT_LAST) && !enh_start) begin
			next_s.tmout = 1'b1;
		end

		// Reverse channel: acknowledge falling edge strobes a byte in, busy low marks a command
		if (rev_mode && (s.rep == 8'h00) && s.ack_q && !acknowledge_in_n_i) begin
			if (!busy_i && !port_lines_i[DATA_RUN_BIT]) begin
				next_s.rle_pend = 1'b1;
				next_s.rle_cnt = port_lines_i[6:0];
			end else if (!busy_i) begin
				next_s.rep = 8'h01;
				next_s.rep_byte = {1'b1, port_lines_i};
			end else begin
				next_s.rep = s.rle_pend ? ({1'b0, s.rle_cnt} + 8'h01) : 8'h01;
				next_s.rep_byte = {1'b0, port_lines_i};
				next_s.rle_pend = 1'b0;
			end
		end else if ((s.rep != 8'h00) && !fifo_full) begin
			push = 1'b1;
			push_data = s.rep_byte;
			next_s.rep = s.rep - 8'h01;
		end

		// Drain the FIFO into the two-entry buffer ahead of the transmitter
		if (fwd_mode && !fifo_empty && (s.buf_cnt != 2'h2)) begin
			pop = 1'b1;
		end
		take = (s.tx_st == TX_IDLE) && (s.buf_cnt != 2'h0) && fwd_mode;
		if (take) begin
			next_s.tx_byte = s.buf0;
			next_s.buf0 = s.buf1;
			next_s.buf_cnt = s.buf_cnt - 2'h1;
		end
		if (pop && fwd_mode) begin
			if (next_s.buf_cnt == 2'h0) begin
				next_s.buf0 = head;
			end else begin
				next_s.buf1 = head;
			end
			next_s.buf_cnt = next_s.buf_cnt + 2'h1;
		end

		// Shared FIFO pointers and storage
		if (push) begin
			next_s.mem[s.wptr[PW-1:0]] = push_data;
			next_s.wptr = s.wptr + (PW + 1)'(1);
		end
		if (pop) begin
			next_s.rptr = s.rptr + (PW + 1)'(1);
		end

		// Forward transmitter: data setup, strobe pulse, wait for busy to fall
		unique case (s.tx_st)
			TX_IDLE: begin
				if (take) begin
					next_s.tx_st = TX_SETUP;
					next_s.tx_cnt = SETUP_LAST;
				end
			end
			TX_SETUP: begin
				next_s.tx_cnt = s.tx_cnt - 8'h01;
				if (s.tx_cnt == 8'h00) begin
					next_s.tx_st = TX_STRB;
					next_s.tx_cnt = STROBE_LAST;
				end
			end
			TX_STRB: begin
				next_s.tx_cnt = s.tx_cnt - 8'h01;
				if (s.tx_cnt == 8'h00) begin
					next_s.tx_st = TX_BUSY;
				end
			end
			TX_BUSY: begin
				if (!busy_i) begin
					next_s.tx_st = TX_IDLE;
				end
			end
			default: begin
				next_s.tx_st = TX_IDLE;
			end
		endcase

		// Standard mode keeps the FIFO and everything fed from it cleared
		if (s.mode == MODE_STD) begin
			next_s.wptr = '0;
			next_s.rptr = '0;
			next_s.buf_cnt = 2'h0;
			next_s.tx_st = TX_IDLE;
			next_s.rep = 8'h00;
			next_s.rle_pend = 1'b0;
		end
		// Leaving enhanced mode mid-cycle drops the cycle instead of leaving strobes stuck
		if (!enh_on) begin
			next_s.enh_st = ENH_IDLE;
		end
	end

	// State register; clock enable freezes everything
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			s <= '0;
			s.mode <= MODE_STD;
			s.ctl <= CTL_RESET;
			s.ext_ctl <= EXT_CTL_RESET;
			s.cfgb <= CONFIG_B_RESET;
			s.wr_n_q <= 1'b1;
			s.rd_n_q <= 1'b1;
			s.ack_q <= 1'b1;
			s.enh_st <= ENH_IDLE;
			s.tx_st <= TX_IDLE;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	// Host side answers; stall while an enhanced cycle runs or a FIFO write meets a full FIFO
	assign io_rdata_o = s.rdata;
	assign irq_o = s.irq;
	assign io_ready_o = (s.enh_st == ENH_IDLE) && !(!io_wr_n_i && fifo_wr_addr && fifo_full);

	// Pin drive: enhanced cycle, then transmitter, then reverse-channel auto feed, then plain control register
	always_comb begin
		port_lines_o = s.data_latch;
		port_lines_oe_o = ~dir_eff;
		strobe_out_o = ~s.ctl[CTL_STB_BIT];
		auto_feed_out_o = ~s.ctl[CTL_AFD_BIT];
		select_in_out_o = ~s.ctl[CTL_SEL_BIT];
		periph_init_n_o = s.ctl[CTL_INIT_BIT];
		if (s.enh_st != ENH_IDLE) begin
			port_lines_o = s.enh_byte;
			port_lines_oe_o = s.enh_wr;
			strobe_out_o = ~s.enh_wr;
			auto_feed_out_o = ~((s.enh_st == ENH_STRB) && !s.enh_addr);
			select_in_out_o = ~((s.enh_st == ENH_STRB) && s.enh_addr);
		end else if (s.tx_st != TX_IDLE) begin
			port_lines_o = s.tx_byte[7:0];
			port_lines_oe_o = 1'b1;
			strobe_out_o = (s.tx_st != TX_STRB);
			if (s.mode == MODE_EXT) begin
				auto_feed_out_o = ~s.tx_byte[8];
			end
		end else if (rev_mode) begin
			auto_feed_out_o = (s.rep != 8'h00); // Held high while run bytes still go in
		end
	end

endmodule // epp_parallel_port

`default_nettype wire

// ===== verilog/epp_pkg.sv
// Constants, encodings and state types of the EPP/ECP parallel port.
// Assumes one 250 MHz system clock and an I/O bus with separate read and write strobes.
package epp_pkg;

	// Register offsets from the decoded base
	localparam logic [15:0] OFF_DATA = 16'h0000;
	localparam logic [15:0] OFF_STATUS = 16'h0001;
	localparam logic [15:0] OFF_CONTROL = 16'h0002;
	localparam logic [15:0] OFF_ENH_ADDR = 16'h0003;
	localparam logic [15:0] OFF_ENH_DATA0 = 16'h0004;
	localparam logic [15:0] OFF_ENH_DATA3 = 16'h0007;
	localparam logic [15:0] OFF_FIFO = 16'h0400;
	localparam logic [15:0] OFF_CONFIG_B = 16'h0401;
	localparam logic [15:0] OFF_EXT_CTL = 16'h0402;

	// Mode codes of extended control bits 7-5
	localparam logic [2:0] MODE_STD = 3'h0;
	localparam logic [2:0] MODE_BIDIR = 3'h1;
	localparam logic [2:0] MODE_FIFO = 3'h2;
	localparam logic [2:0] MODE_EXT = 3'h3;
	localparam logic [2:0] MODE_ENH = 3'h4;
	localparam logic [2:0] MODE_RSVD = 3'h5;
	localparam logic [2:0] MODE_TEST = 3'h6;
	localparam logic [2:0] MODE_CFG = 3'h7;

	// Field positions
	localparam int CTL_DIR_BIT = 5;
	localparam int CTL_IRQEN_BIT = 4;
	localparam int CTL_SEL_BIT = 3;
	localparam int CTL_INIT_BIT = 2;
	localparam int CTL_AFD_BIT = 1;
	localparam int CTL_STB_BIT = 0;
	localparam int STAT_TMOUT_BIT = 0;
	localparam int DATA_RUN_BIT = 7;

	// Reset and fixed read values
	localparam logic [5:0] CTL_RESET = 6'h04;
	localparam logic [2:0] EXT_CTL_RESET = 3'h5;
	localparam logic [5:0] CONFIG_B_RESET = 6'h3F;
	localparam logic [7:0] CONFIG_A_VALUE = 8'h10;
	localparam logic [7:0] UNMAPPED_READ = 8'hFF;
	localparam logic [1:0] ONES2 = 2'h3;
	localparam logic [2:0] ONES3 = 3'h7;

	// Timing
	localparam int CLK_MHZ = 250;
	localparam int ENH_TIMEOUT_US = 10;
	localparam int ENH_TIMEOUT_CYC = ENH_TIMEOUT_US * CLK_MHZ;
	localparam int TX_SETUP_NS = 500;
	localparam int TX_SETUP_CYC = (TX_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int TX_STROBE_NS = 500;
	localparam int TX_STROBE_CYC = (TX_STROBE_NS * CLK_MHZ + 999) / 1000;

	// Enhanced cycle sequencer
	typedef enum logic [2:0] {
		ENH_IDLE = 3'b001,
		ENH_HOLD = 3'b010,
		ENH_STRB = 3'b100
	} epp_enh_state_e;

	// Forward byte transmitter
	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_SETUP = 4'b0010,
		TX_STRB = 4'b0100,
		TX_BUSY = 4'b1000
	} epp_tx_state_e;

endpackage

// ===== tb/epp_parallel_port_assertions.sv
// Concurrent checks on the parallel port's pins and I/O bus.
// Assumes a bind into the port; the strobes and pins share the one system clock.
`timescale 1ns/10ps
`default_nettype none
module epp_chk
	import epp_pkg::*;
#(
	parameter int TIMEOUT_CYC = ENH_TIMEOUT_CYC
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [15:0] io_addr_i,
	input wire logic io_wr_n_i,
	input wire logic io_rd_n_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic [7:0] io_rdata_o,
	input wire logic io_ready_o,
	input wire logic irq_o,
	input wire logic [15:0] base_addr_config_i,
	input wire logic legacy_handshake_i,
	input wire logic port_lines_oe_o,
	input wire logic strobe_out_o,
	input wire logic auto_feed_out_o,
	input wire logic select_in_out_o,
	input wire logic periph_init_n_o,
	input wire logic acknowledge_in_n_i,
	input wire logic busy_i,
	input wire logic paper_error_in_i,
	input wire logic select_i,
	input wire logic fault_in_n_i
);
	// A few cycles of slack beyond the abort point for start and end registers
	localparam int TO_MAX = TIMEOUT_CYC + 4;
	logic wr_q, rd_q, wr_take, rd_take, epp_busy;
	logic [15:0] busy_run;
	logic [15:0] off;
	assign off = io_addr_i - base_addr_config_i;
	assign wr_take = ce_i && io_wr_n_i && !wr_q;
	assign rd_take = ce_i && !io_rd_n_i && rd_q;
	// Ready low with both strobes idle can only mean an enhanced cycle
	assign epp_busy = !io_ready_o && io_wr_n_i && io_rd_n_i;
	// Strobe history, frozen with the clock enable like the port's own detectors
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wr_q <= 1'b1;
			rd_q <= 1'b1;
			busy_run <= 16'h0000;
		end else if (ce_i) begin
			wr_q <= io_wr_n_i;
			rd_q <= io_rd_n_i;
			// Counted, since the default timeout is far beyond a delay range
			busy_run <= epp_busy ? (busy_run + 16'h0001) : 16'h0000;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	chk_ctl_pins: assert property (
		wr_take && io_ready_o && off == OFF_CONTROL |=>
		strobe_out_o == !$past(io_wdata_i[CTL_STB_BIT]) &&
		auto_feed_out_o == !$past(io_wdata_i[CTL_AFD_BIT]) &&
		select_in_out_o == !$past(io_wdata_i[CTL_SEL_BIT]) &&
		periph_init_n_o == $past(io_wdata_i[CTL_INIT_BIT])) else $error("control pins wrong");
	chk_status_read: assert property (
		rd_take && off == OFF_STATUS |=> io_rdata_o[7:1] == {!$past(busy_i),
		$past(acknowledge_in_n_i), $past(paper_error_in_i), $past(select_i),
		$past(fault_in_n_i), ONES2}) else $error("status read wrong");
	chk_ctl_read: assert property (
		rd_take && off == OFF_CONTROL |=> io_rdata_o[7:6] == ONES2) else $error("ctl top bits");
	chk_unmapped_read: assert property (
		rd_take && off >= 16'h0008 && off < OFF_FIFO |=> io_rdata_o == UNMAPPED_READ)
		else $error("unmapped read not FF");
	chk_irq_pulse: assert property (
		irq_o |=> !irq_o) else $error("irq longer than a cycle");
	chk_one_strobe: assert property (
		epp_busy |-> auto_feed_out_o || select_in_out_o) else $error("both strobes low");
	chk_write_drive: assert property (
		epp_busy && !strobe_out_o && !(auto_feed_out_o && select_in_out_o) |-> port_lines_oe_o)
		else $error("write strobe without drive");
	chk_cycle_bound: assert property (
		busy_run <= TO_MAX) else $error("enhanced cycle not aborted");
	chk_wait_first: assert property (
		!legacy_handshake_i && epp_busy && ($fell(auto_feed_out_o) || $fell(select_in_out_o))
		|-> !$past(busy_i)) else $error("strobe while wait high");
	cov_epp_read: cover property (epp_busy && strobe_out_o && !auto_feed_out_o);
	cov_epp_write: cover property (epp_busy && !strobe_out_o && !select_in_out_o);
	cov_irq: cover property (irq_o);
endmodule // epp_chk
bind epp_parallel_port epp_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (.clk_sys_i, .reset_i, .ce_i,
	.io_addr_i, .io_wr_n_i, .io_rd_n_i, .io_wdata_i, .io_rdata_o, .io_ready_o, .irq_o,
	.base_addr_config_i, .legacy_handshake_i, .port_lines_oe_o, .strobe_out_o, .auto_feed_out_o,
	.select_in_out_o, .periph_init_n_o, .acknowledge_in_n_i, .busy_i, .paper_error_in_i,
	.select_i, .fault_in_n_i);
`default_nettype wire

// ===== tb/epp_periph_model.sv
// Behavioural peripheral on the enhanced link: answers strobes on the wait line.
// Assumes the bench says when the link is in enhanced use, so plain control pins are ignored.
`timescale 1ns/10ps
`default_nettype none
module epp_periph_model #(
	parameter int DELAY = 3,
	parameter logic [7:0] RD_BYTE = 8'h96
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic epp_on_i,
	input wire logic hold_i,
	input wire logic stall_i,
	input wire logic rw_select_n_i,
	input wire logic data_strobe_n_i,
	input wire logic addr_strobe_n_i,
	input wire logic [7:0] port_lines_dut_i,
	input wire logic port_lines_oe_i,
	output logic [7:0] port_lines_o,
	output logic periph_wait_n_o,
	output logic [7:0] cap_byte_o,
	output logic cap_addr_o,
	output logic cap_rw_o,
	output logic [7:0] cap_count_o
);
	int cnt;
	// Peripheral drives the lines only while the port has released them
	assign port_lines_o = port_lines_oe_i ? port_lines_dut_i : RD_BYTE;
	// Wait rises DELAY cycles into a strobe and falls once the strobe ends
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			cnt <= 0;
			periph_wait_n_o <= 1'b0;
			cap_count_o <= 8'h00;
		end else if (!epp_on_i) begin
			cnt <= 0;
			periph_wait_n_o <= 1'b0;
		end else if (data_strobe_n_i && addr_strobe_n_i) begin
			cnt <= 0;
			periph_wait_n_o <= hold_i;
		end else if (hold_i || stall_i) begin
			cnt <= 0;
			periph_wait_n_o <= hold_i;
		end else if (cnt == DELAY) begin
			cnt <= cnt + 1;
			periph_wait_n_o <= 1'b1;
			cap_byte_o <= port_lines_o;
			cap_addr_o <= !addr_strobe_n_i;
			cap_rw_o <= rw_select_n_i;
			cap_count_o <= cap_count_o + 8'h01;
		end else if (cnt < DELAY) begin
			cnt <= cnt + 1;
			// Pulled low first so an older-rule host sees a real low-high edge
			periph_wait_n_o <= 1'b0;
		end
	end
endmodule // epp_periph_model
`default_nettype wire

// ===== tb/epp_parallel_port_tb.sv
// Self-checking bench of the parallel port: register tasks on the I/O strobes, peripheral model.
// Assumes one 250 MHz clock and a short enhanced-cycle timeout to keep the run brief.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module epp_parallel_port_tb;
	import epp_pkg::*;
	localparam int TO_CYC = 20;
	localparam logic [15:0] BASE = 16'h0280;
	localparam logic [7:0] RD_BYTE = 8'h96;
	logic clk_sys_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1;
	logic [15:0] io_addr_i = 16'h0000, base_addr_config_i = BASE;
	logic io_wr_n_i = 1'b1, io_rd_n_i = 1'b1;
	logic [7:0] io_wdata_i = 8'h00;
	logic enhanced_option_config_i = 1'b0, chip_mode_config_i = 1'b0, legacy_handshake_i = 1'b0;
	logic acknowledge_in_n_i = 1'b1, paper_error_in_i = 1'b1, select_i = 1'b0, fault_in_n_i = 1'b1;
	logic epp_on = 1'b0, hold = 1'b0, stall = 1'b0;
	logic [7:0] io_rdata_o, port_lines_o, port_lines_i, cap_byte, cap_count, v, c;
	logic io_ready_o, irq_o, port_lines_oe_o, strobe_out_o, auto_feed_out_o, select_in_out_o;
	logic periph_init_n_o, busy_i, cap_addr, cap_rw;
	logic [3:0] pins;
	logic [7:0] ctl_tab [3] = '{8'hFF, 8'h00, 8'h0A};
	logic [15:0] op_off [4] = '{OFF_ENH_ADDR, OFF_ENH_DATA0, OFF_ENH_ADDR, OFF_ENH_DATA3};
	int fail_count = 0;
	int cmp_count = 0;
	int pulses;
	assign pins = {strobe_out_o, auto_feed_out_o, select_in_out_o, periph_init_n_o};
	// Clock of 4 ns
	always #2 clk_sys_i = ~clk_sys_i;
	epp_parallel_port #(.TIMEOUT_CYC(TO_CYC)) i_dut (.clk_sys_i, .reset_i, .ce_i, .io_addr_i,
		.io_wr_n_i, .io_rd_n_i, .io_wdata_i, .io_rdata_o, .io_ready_o, .irq_o, .base_addr_config_i,
		.enhanced_option_config_i, .chip_mode_config_i, .legacy_handshake_i, .port_lines_i,
		.port_lines_o, .port_lines_oe_o, .strobe_out_o, .auto_feed_out_o, .select_in_out_o,
		.periph_init_n_o, .acknowledge_in_n_i, .busy_i, .paper_error_in_i, .select_i, .fault_in_n_i);
	epp_periph_model #(.RD_BYTE(RD_BYTE)) i_periph (.clk_sys_i, .reset_i, .epp_on_i(epp_on),
		.hold_i(hold), .stall_i(stall), .rw_select_n_i(strobe_out_o),
		.data_strobe_n_i(auto_feed_out_o), .addr_strobe_n_i(select_in_out_o),
		.port_lines_dut_i(port_lines_o), .port_lines_oe_i(port_lines_oe_o),
		.port_lines_o(port_lines_i), .periph_wait_n_o(busy_i), .cap_byte_o(cap_byte),
		.cap_addr_o(cap_addr), .cap_rw_o(cap_rw), .cap_count_o(cap_count));
	// Every change lands 1 ns after an edge, well clear of sampling
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		step(1);
		while (io_ready_o !== 1'b1 && n < 200) begin
			step(1);
			n++;
		end
		`CHK(io_ready_o, 1'b1)
	endtask
	task automatic issue_wr(input logic [15:0] off, input logic [7:0] d);
		io_addr_i = BASE + off;
		io_wdata_i = d;
		io_wr_n_i = 1'b0;
		step(1);
		io_wr_n_i = 1'b1;
	endtask
	// The extra step keeps the strobes high a cycle between accesses
	task automatic io_wr(input logic [15:0] off, input logic [7:0] d);
		issue_wr(off, d);
		wait_ready();
		step(1);
	endtask
	task automatic io_rd(input logic [15:0] off, output logic [7:0] d);
		io_addr_i = BASE + off;
		io_rd_n_i = 1'b0;
		step(1);
		io_rd_n_i = 1'b1;
		wait_ready();
		d = io_rdata_o;
		step(1);
	endtask
	// Counts interrupt pulses after one acknowledge low-high
	task automatic ack_pulse(output int p);
		p = 0;
		acknowledge_in_n_i = 1'b0;
		step(3);
		acknowledge_in_n_i = 1'b1;
		repeat (6) begin
			step(1);
			if (irq_o === 1'b1) p++;
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		step(4);
		reset_i = 1'b0;
		io_rd(OFF_CONTROL, v);
		`CHK(v, 8'hC4)
		`CHK(pins, 4'hF)
		io_rd(OFF_EXT_CTL, v);
		`CHK(v, 8'h15)
		io_rd(OFF_STATUS, v);
		`CHK(v, 8'hEF)
		io_rd(16'h0005, v);
		`CHK(v, 8'hFF)
		foreach (ctl_tab[i]) begin
			c = ctl_tab[i];
			io_wr(OFF_CONTROL, c);
			`CHK(pins, {~c[0], ~c[1], ~c[3], c[2]})
			io_rd(OFF_CONTROL, v);
			`CHK(v, {2'b11, 1'b0, c[4:0]})
		end
		io_wr(OFF_CONTROL, 8'h14);
		ack_pulse(pulses);
		`CHK(pulses, 1)
		io_wr(OFF_CONTROL, 8'h04);
		ack_pulse(pulses);
		`CHK(pulses, 0)
		// A write while the clock enable is low must leave every register alone
		ce_i = 1'b0;
		io_wr(OFF_CONTROL, 8'h0B);
		ce_i = 1'b1;
		`CHK(pins, 4'hF)
		io_wr(OFF_DATA, 8'hA5);
		`CHK(port_lines_o, 8'hA5)
		io_rd(OFF_DATA, v);
		`CHK(v, 8'hA5)
		io_wr(OFF_EXT_CTL, 8'h20);
		io_wr(OFF_CONTROL, 8'h24);
		`CHK(port_lines_oe_o, 1'b0)
		io_rd(OFF_DATA, v);
		`CHK(v, RD_BYTE)
		io_wr(OFF_EXT_CTL, 8'h40);
		`CHK(port_lines_oe_o, 1'b1)
		io_wr(OFF_CONTROL, 8'h04);
		for (int m = 0; m < 8; m++) begin
			io_wr(OFF_EXT_CTL, {m[2:0], 5'h00});
			io_rd(OFF_EXT_CTL, v);
			`CHK(v[7:5], m[2:0])
		end
		// Enhanced mode without the configuration option stays plain
		epp_on = 1'b1;
		io_wr(OFF_EXT_CTL, 8'h80);
		io_wr(OFF_ENH_DATA0, 8'h11);
		`CHK(cap_count, 8'h00)
		enhanced_option_config_i = 1'b1;
		chip_mode_config_i = 1'b1;
		foreach (op_off[k]) begin
			if (k < 2) begin
				io_wr(op_off[k], 8'h30 + k[7:0]);
			end else begin
				io_rd(op_off[k], v);
			end
			`CHK(cap_addr, (op_off[k] == OFF_ENH_ADDR))
			`CHK(cap_rw, (k >= 2))
			`CHK(k < 2 ? cap_byte : v, k < 2 ? 8'h30 + k[7:0] : RD_BYTE)
			`CHK(cap_count, 8'h01 + k[7:0])
		end
		hold = 1'b1;
		step(2);
		issue_wr(OFF_ENH_DATA0, 8'h5A);
		step(5);
		`CHK({auto_feed_out_o, io_ready_o}, 2'b10)
		hold = 1'b0;
		wait_ready();
		step(1);
		`CHK(cap_byte, 8'h5A)
		legacy_handshake_i = 1'b1;
		hold = 1'b1;
		step(2);
		issue_wr(OFF_ENH_DATA0, 8'hC3);
		step(3);
		`CHK({auto_feed_out_o, io_ready_o}, 2'b00)
		hold = 1'b0;
		wait_ready();
		step(1);
		`CHK(cap_byte, 8'hC3)
		legacy_handshake_i = 1'b0;
		io_rd(OFF_STATUS, v);
		`CHK(v[0], 1'b0)
		// Silent peripheral: the watchdog must end the cycle near its count
		stall = 1'b1;
		issue_wr(OFF_ENH_DATA0, 8'h77);
		step(TO_CYC - 4);
		`CHK(io_ready_o, 1'b0)
		wait_ready();
		step(1);
		stall = 1'b0;
		io_rd(OFF_STATUS, v);
		`CHK(v[0], 1'b1)
		io_wr(OFF_STATUS, 8'h00);
		io_rd(OFF_STATUS, v);
		`CHK(v[0], 1'b1)
		io_wr(OFF_STATUS, 8'h01);
		io_rd(OFF_STATUS, v);
		`CHK(v[0], 1'b0)
		// Mode 011 forward: a data-port byte goes out tagged, setup then strobe
		epp_on = 1'b0;
		io_wr(OFF_EXT_CTL, 8'h60);
		io_wr(OFF_DATA, 8'h5C);
		step(2);
		`CHK({port_lines_o, auto_feed_out_o, strobe_out_o}, {8'h5C, 2'b01})
		step(TX_SETUP_CYC);
		`CHK({port_lines_o, strobe_out_o}, {8'h5C, 1'b0})
		// Test mode exercises the shared FIFO to full and back to empty
		epp_on = 1'b0;
		io_wr(OFF_EXT_CTL, 8'hC0);
		for (int i = 0; i < 16; i++) begin
			io_wr(OFF_FIFO, 8'hE0 + i[7:0]);
		end
		io_rd(OFF_EXT_CTL, v);
		`CHK(v[1:0], 2'b10)
		for (int i = 0; i < 16; i++) begin
			io_rd(OFF_FIFO, v);
			`CHK(v, 8'hE0 + i[7:0])
		end
		io_rd(OFF_EXT_CTL, v);
		`CHK(v[1:0], 2'b01)
		io_wr(OFF_FIFO, 8'h42);
		io_wr(OFF_EXT_CTL, 8'h00);
		io_wr(OFF_EXT_CTL, 8'hC0);
		io_rd(OFF_EXT_CTL, v);
		`CHK(v[1:0], 2'b01)
		finish_test();
	end
	// Watchdog at about twenty times the expected run
	initial begin
		#40000;
		fail_count++;
		finish_test();
	end
endmodule // epp_parallel_port_tb
`default_nettype wire
